/* File: fir_host_port_defs.vh */
// constants for the fir coefficient host load port
`ifndef FIR_HOST_PORT_DEFS_VH
`define FIR_HOST_PORT_DEFS_VH
`define CTRL_RESET        16'h8c80
`define CTRL_SINGLE_BIT   15
`define CTRL_RATE_HI      14
`define CTRL_RATE_LO      13
`define CTRL_DECIM_BIT    12
`define CTRL_ROLE_HI      11
`define CTRL_ROLE_LO      10
`define CTRL_SWREG_BIT    7
`define CTRL_BANK_BIT     6
`define CTRL_ALT_BIT      5
`define CTRL_CASC_BIT     4
`define CTRL_ZERO_MASK    16'h030f
`define BUSY_CYCLES       22
`define BUSY_CNT_W        5
`endif

/* File: fir_coeff_host_load_port.v */
// host write port and double buffered control register of the fir filter
// What this block and its host must do
// (R1) Host holds rom master select high
// (R2) No read path for stored coefficients
// (R3) Load only when select and write low
// (R4) Control select picks control versus coefficients
// (R5) Host holds select two extra cycles
// (R6) Coefficient as word or two bytes
// (R7) Byte mode eight address bits, word seven
// (R8) Host writes low byte before high byte
// (R9) Byte mode needs equal upper nibbles
// (R10) Host drives bus synchronous to clock
// (R11) All internal writes use system clock
// (R12) Host waits busy low or 22 cycles
// (R13) Control first, then one idle cycle
// (R14) Host raises filter go with first data
// (R15) One 16-bit control register for all
// (R16) Bit 15 single, bit 4 cascade mode
// (R17) Bits 14:13 sample rate divisor
// (R18) Bit 12 decimate, bits 11:10 cascade role
// (R19) Host writes zero to reserved bits
// (R20) Bit 7 picks pin or bit 6 bank
// (R21) Bit 5 alternates bank each sample
// (R22) Written control word waits in shadow
// (R23) First write after reset loads directly
// (R24) Control resets to 8c80
// (R25) Bank change at next sample tick
// (R26) Byte mode commits coefficient on high byte
`timescale 1ns/100ps
`include "fir_host_port_defs.vh"

module fir_coeff_host_load_port #(
  parameter ADDR_W = 8,
  parameter COEF_W = 16
) (
  // clock and reset
  input  wire              clk,
  input  wire              rstn,
  // host write port
  input  wire              cs_n,
  input  wire              wen_n,
  input  wire              ctrl_word_select,
  input  wire              byte_mode_n,
  input  wire [ADDR_W-1:0] addr,
  input  wire [COEF_W-1:0] coef_bus,
  // bank swap pin and filter start
  input  wire              swap_pin,
  input  wire              filter_go,
  // status
  output reg               busy,
  // coefficient write to storage
  output reg               coef_we,
  output reg  [6:0]        coef_addr,
  output reg  [COEF_W-1:0] coef_data,
  // active configuration
  output reg  [15:0]       active_ctrl,
  output wire              single_filter,
  output wire              cascade_filters,
  output wire [1:0]        rate_code,
  output wire              decimate,
  output wire [1:0]        cascade_role,
  // sample tick and bank in use
  output reg               sample_tick,
  output reg               bank_upper
);

  // ----------------------------------------------------------------
  // host write decode
  // ----------------------------------------------------------------
  reg  [15:0]       shadow_ctrl_r;
  reg               first_ctrl_r;
  reg               pend_r;
  reg  [7:0]        low_byte_r;
  reg  [`BUSY_CNT_W-1:0] busy_cnt_r;
  reg  [2:0]        div_cnt_r;
  reg               swap_src_d_r;
  reg               alt_bank_r;
  reg               go_d_r;

  wire byte_mode = ~byte_mode_n;
  wire write_hit = ~cs_n & ~wen_n; // R3
  wire nib_ok = coef_bus[15:12] == coef_bus[11:8]; // R9
  wire accept = write_hit & (~byte_mode | nib_ok); // R9
  wire ctrl_wr = accept & ctrl_word_select;
  wire coef_wr = accept & ~ctrl_word_select;

  // control word as assembled from this write
  wire [15:0] ctrl_in = byte_mode ?
    (addr[0] ? {coef_bus[7:0], shadow_ctrl_r[7:0]}
             : {shadow_ctrl_r[15:8], coef_bus[7:0]})
    : coef_bus;

  // swap source from register bit or pin
  wire swap_src = active_ctrl[`CTRL_SWREG_BIT] ?
    active_ctrl[`CTRL_BANK_BIT] : swap_pin; // R20

  // sample tick period from rate code
  function [2:0] div_last;
    input [1:0] code;
    begin
      case (code)
        2'b00:   div_last = 3'h0;
        2'b01:   div_last = 3'h1;
        2'b10:   div_last = 3'h3;
        default: div_last = 3'h7;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // decoded mode fields
  // ----------------------------------------------------------------
  assign single_filter   = active_ctrl[`CTRL_SINGLE_BIT]; // R16
  assign cascade_filters = ~active_ctrl[`CTRL_SINGLE_BIT] &
                           active_ctrl[`CTRL_CASC_BIT]; // R16
  assign rate_code = active_ctrl[`CTRL_RATE_HI:`CTRL_RATE_LO]; // R17
  assign decimate  = active_ctrl[`CTRL_DECIM_BIT]; // R18
  assign cascade_role = active_ctrl[`CTRL_ROLE_HI:`CTRL_ROLE_LO]; // R18

  // ----------------------------------------------------------------
  // busy after reset
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_cnt_r <= 5'h00;
      busy       <= 1'b1;
    end else if (busy) begin
      busy_cnt_r <= busy_cnt_r + 5'h01;
      if (busy_cnt_r == `BUSY_CYCLES - 1)
        busy <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control register, shadow and active copies
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shadow_ctrl_r <= `CTRL_RESET; // R24
      active_ctrl   <= `CTRL_RESET; // R24
      first_ctrl_r  <= 1'b1;
      pend_r        <= 1'b0;
      swap_src_d_r  <= 1'b0;
    end else begin
      swap_src_d_r <= swap_src;
      if (ctrl_wr) begin
        shadow_ctrl_r <= ctrl_in & ~`CTRL_ZERO_MASK; // R15
        if (first_ctrl_r) begin
          active_ctrl <= ctrl_in & ~`CTRL_ZERO_MASK; // R23
          // byte mode: direct load lasts until high byte lands
          if (~byte_mode | addr[0])
            first_ctrl_r <= 1'b0;
        end else begin
          pend_r <= 1'b1; // R22
        end
      end else if (pend_r & (swap_src != swap_src_d_r)) begin
        active_ctrl <= shadow_ctrl_r; // R22
        pend_r      <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // coefficient write path, write only, no readback mux
  // (R2)
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_byte_r <= 8'h00;
      coef_we    <= 1'b0;
      coef_addr  <= 7'h00;
      coef_data  <= 16'h0000;
    end else begin
      coef_we <= 1'b0;
      if (coef_wr) begin // R11
        if (byte_mode) begin
          if (!addr[0]) begin
            low_byte_r <= coef_bus[7:0]; // R26
          end else begin
            coef_we   <= 1'b1; // R6
            coef_addr <= addr[7:1]; // R7
            coef_data <= {coef_bus[7:0], low_byte_r}; // R26
          end
        end else begin
          coef_we   <= 1'b1; // R6
          coef_addr <= addr[6:0]; // R7
          coef_data <= coef_bus;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // sample tick and bank selection
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt_r   <= 3'h0;
      sample_tick <= 1'b0;
      bank_upper  <= 1'b0;
      alt_bank_r  <= 1'b0;
      go_d_r      <= 1'b0;
    end else begin
      go_d_r <= filter_go;
      if (div_cnt_r >= div_last(rate_code)) begin
        div_cnt_r   <= 3'h0;
        sample_tick <= 1'b1;
      end else begin
        div_cnt_r   <= div_cnt_r + 3'h1;
        sample_tick <= 1'b0;
      end
      if (filter_go & ~go_d_r)
        alt_bank_r <= 1'b0;
      else if (sample_tick)
        alt_bank_r <= ~alt_bank_r;
      if (sample_tick) begin // R25
        if (active_ctrl[`CTRL_ALT_BIT])
          bank_upper <= alt_bank_r; // R21
        else
          bank_upper <= swap_src; // R20
      end
    end
  end

endmodule

/* File: host_port_props.sv */
// assertion checker of the host load port outputs
`timescale 1ns/100ps
module host_port_props (
  // clock, reset and host inputs
  input wire        clk,
  input wire        rstn,
  input wire        cs_n,
  input wire        wen_n,
  input wire        ctrl_word_select,
  input wire        byte_mode_n,
  input wire [7:0]  addr,
  input wire [15:0] coef_bus,
  // outputs under watch
  input wire        coef_we,
  input wire [6:0]  coef_addr,
  input wire [15:0] coef_data,
  input wire [15:0] active_ctrl,
  input wire        single_filter,
  input wire        cascade_filters,
  input wire [1:0]  rate_code,
  input wire        decimate,
  input wire [1:0]  cascade_role,
  input wire        sample_tick,
  input wire        bank_upper
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // coefficient write taken at this edge
  wire wr = !cs_n && !wen_n && !ctrl_word_select;
  mode_single_a: assert property (single_filter == active_ctrl[15])
    else $error("single flag wrong");
  mode_casc_a: assert property (
    cascade_filters == (active_ctrl[4] & ~active_ctrl[15]))
    else $error("cascade flag wrong");
  idle_quiet_a: assert property (cs_n || wen_n |=> !coef_we)
    else $error("commit without write");
  word_commit_a: assert property (wr && byte_mode_n |=> coef_we &&
    coef_data == $past(coef_bus) && coef_addr == $past(addr[6:0]))
    else $error("word commit wrong");
  byte_low_a: assert property (wr && !byte_mode_n && !addr[0] |=>
    !coef_we) else $error("low byte committed");
  nibble_ref_a: assert property (wr && !byte_mode_n &&
    coef_bus[15:12] != coef_bus[11:8] |=> !coef_we)
    else $error("nibble mismatch accepted");
  bank_hold_a: assert property (!$past(sample_tick) |->
    $stable(bank_upper)) else $error("bank moved off tick");
  resv_zero_a: assert property ((active_ctrl & 16'h030f) == 16'h0)
    else $error("reserved bits set");
  rate_decode_a: assert property (rate_code == active_ctrl[14:13])
    else $error("rate code wrong");
  decim_role_a: assert property (decimate == active_ctrl[12] &&
    cascade_role == active_ctrl[11:10]) else $error("decim or role wrong");
endmodule
bind fir_coeff_host_load_port host_port_props u_props (.*);

/* File: remote_master.sv */
// remote master model driving the host write port
`timescale 1ns/100ps
module remote_master (
  // system clock
  input wire         clk,
  // host write port
  output reg         cs_n = 1'b1,
  output reg         wen_n = 1'b1,
  output reg         ctrl_word_select = 1'b0,
  output reg  [7:0]  addr = 8'h00,
  output reg  [15:0] coef_bus = 16'h0000
);
  // rom master select is taken as tied high by this host
  // one write; control keeps select two cycles more
  // control select is driven from the task input c, apart from addr
  task wr(input c, input [7:0] a, input [15:0] d);
    begin
      @(posedge clk);
      #1;
      {cs_n, wen_n, ctrl_word_select, addr, coef_bus} = {2'b00, c, a, d};
      @(posedge clk);
      #1;
      wen_n = 1'b1;
      addr = ~addr;
      coef_bus = ~coef_bus;
      if (c) begin
        repeat (2) @(posedge clk);
        #1;
      end
      cs_n = 1'b1;
    end
  endtask
endmodule

/* File: fir_coeff_host_load_port_tb.sv */
// self-checking bench of the fir coefficient host load port
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
  fail_count++; $display("MISMATCH %0t value differs", $time); end end
module fir_coeff_host_load_port_tb;
  reg        clk = 0, rstn = 0, byte_mode_n = 1, swap_pin = 0, filter_go = 0;
  wire       cs_n, wen_n, ctrl_word_select, busy, coef_we, bank_upper;
  wire [7:0] addr;
  wire [6:0] coef_addr;
  wire [15:0] coef_bus, coef_data, active_ctrl;
  int        fail_count = 0, n_compared = 0, k;
  reg [31:0] lfsr = 32'hf9ea, v;
  reg [22:0] q[$];
  remote_master u_host (.*);
  fir_coeff_host_load_port u_dut (.*, .single_filter(), .cascade_filters(),
    .rate_code(), .decimate(), .cascade_role(), .sample_tick());
  // ----------------------------------------
  // clock, random source and verdict
  // ----------------------------------------
  initial forever #12.5 clk = ~clk;
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task give_verdict;
    if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #50000;
    fail_count++;
    give_verdict;
  end
  // compare every committed coefficient with the model queue
  always @(posedge clk)
    if (coef_we === 1'b1) `CHK({coef_addr, coef_data}, q.pop_front())
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    #1;
    `CHK(active_ctrl, 16'h8c80)
    `CHK(busy, 1'b1)
    rstn = 1;
    k = 0;
    while (busy === 1'b1 && k < 40) begin
      @(posedge clk);
      #1 k++;
    end
    `CHK(k, 22)
    u_host.wr(1, 8'h00, 16'he800);
    `CHK(active_ctrl, 16'he800)
    u_host.wr(1, 8'h00, 16'h0cd0);
    `CHK(active_ctrl, 16'he800)
    swap_pin = 1;
    repeat (3) @(posedge clk);
    #1;
    `CHK(active_ctrl, 16'h0cd0)
    repeat (6) @(posedge clk);
    #1;
    `CHK(bank_upper, 1'b1)
    filter_go = 1;
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      q.push_back({v[6:0], v[31:16]});
      u_host.wr(0, v[7:0], v[31:16]);
    end
    byte_mode_n = 0;
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      q.push_back({v[7:1], v[31:16]});
      u_host.wr(0, {v[7:1], 1'b0}, {8'h00, v[23:16]});
      u_host.wr(0, {v[7:1], 1'b1}, {8'h00, v[31:24]});
    end
    u_host.wr(0, 8'h01, 16'h1055);
    repeat (3) @(posedge clk);
    `CHK(q.size(), 0)
    #1 rstn = 0;
    #1 `CHK(active_ctrl, 16'h8c80)
    give_verdict;
  end
endmodule
